// file: verilog/sdft_pkg.sv
/*
 * Constants of the segment display frame timing block: register map,
 * field positions, reset values, clock sources, timing counts, levels.
 * Assumes a 32-bit AXI4-Lite register bus and 8-bit registers.
 */
package sdft_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam int NUM_DATA = 12;
	localparam logic [7:0] DATA_BASE = 8'h00;
	localparam logic [7:0] CTRL_ADDR = 8'h30;
	localparam logic [7:0] PRESC_ADDR = 8'h34;
	localparam logic [7:0] STAT_ADDR = 8'h38;
	// ==========================================================
	// display_control_reg fields and register reset values
	localparam int CTRL_EN = 7;
	localparam int CTRL_SLP = 6;
	localparam int CTRL_WRITE_ERROR_FLAG = 5;
	localparam int CTRL_WAVEB = 4;
	localparam int CTRL_CS_LO = 2;
	localparam int CTRL_MUX_LO = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] PRESC_RESET = 4'h0;
	localparam logic [7:0] PIXEL_RESET = 8'h00;
	// status register fields
	localparam int STAT_ACT = 0;
	localparam int STAT_IRQ = 1;
	// ==========================================================
	// clock sources and multiplex modes
	localparam logic [1:0] CS_SYSDIV = 2'h0;
	localparam logic [1:0] CS_SEC = 2'h1;
	localparam logic [1:0] CS_LF = 2'h2;
	localparam logic [1:0] MUX_STATIC = 2'h0;
	localparam logic [1:0] MUX_HALF = 2'h1;
	// ==========================================================
	// timing counts
	localparam logic [7:0] SYSDIV_LAST = 8'hFF;
	localparam logic [4:0] SLOT_LAST = 5'h1F;
	localparam logic [5:0] PRE_STATIC = 6'h04;
	localparam logic [5:0] PRE_HALF = 6'h02;
	localparam logic [5:0] PRE_MULTI = 6'h01;
	// ==========================================================
	// drive levels, bus answers, line counts, states
	localparam logic [1:0] LVL0 = 2'h0;
	localparam logic [1:0] LVL1 = 2'h1;
	localparam logic [1:0] LVL2 = 2'h2;
	localparam logic [1:0] LVL3 = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int NUM_SEG = 19;
	localparam int NUM_COM = 4;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} sdft_state_t;
endpackage : sdft_pkg

// file: verilog/sdft_top.sv
/*
 * Segment display frame timing: prescaler, common/segment waveform
 * levels, shutdown and frame events, write window, AXI4-Lite slave.
 * Assumes oscillator pins are asynchronous to aclk and sleep_cmd is
 * on aclk. Level codes go to an external bias ladder.
 */
// Behaviour
// - static frame = clock / (4 * prescale * 32 * 1).
// - half multiplex frame = clock / (2 * prescale * 32 * 2).
// - third/quarter frame = clock / (prescale * 32 * commons).
// - clock from system clock/256, secondary crystal or low-freq osc.
// - pixel bits map segments 0-15 and 16-18 to bits 0-15 and 21-23 of each common's three data registers.
// - common minus segment has zero DC; lit pixels get higher RMS.
// - per-common mode inverts in each slot; per-frame inverts per frame.
// - sleep with divided system clock halts the driver at once.
// - shutdown completion (active falls) raises the interrupt.
// - a frame starts at the leading edge of common 0.
// - frame interrupt set once all pixel data of the frame is read.
// - per-frame mode interrupts only at complete phase intervals.
// - pixel write while active in per-frame non-static mode outside the write window is dropped and sets write error.
// - no frame interrupt in per-common mode or per-frame static mode.
// - selector 00/01/10/11 enables commons 0, 0-1, 0-2, 0-3.
// - sleep with sleep-stop stops at once, all outputs minimum level.
// - after enable clears, finish frame, then clear active flag.
`timescale 1ns/1ps
module sdft_top (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset
	input wire logic clk_en, // freezes all state when low
	input wire logic sleep_cmd, // processor asleep
	input wire logic sec_osc_pin, // secondary crystal oscillator
	input wire logic lf_osc_pin, // low-frequency internal oscillator
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [7:0] backplane_lvl, // 2-bit level per common
	output logic [37:0] segment_line_lvl, // 2-bit level per segment
	output logic display_irq // display interrupt flag
);
	// ==========================================================
	// functions
	function automatic logic pixel_bit(input logic [7:0] px [12],
		input logic [1:0] com, input int segment_line);
		logic [3:0] base;
		base = 4'(com) * 4'h3;
		if (segment_line < 8) pixel_bit = px[base][segment_line];
		else if (segment_line < 16) pixel_bit = px[base + 4'h1][segment_line - 8];
		else pixel_bit = px[base + 4'h2][segment_line - 11];
	endfunction : pixel_bit

	function automatic logic [5:0] pre_len(input logic [1:0] mux,
		input logic [3:0] lp);
		logic [5:0] p;
		p = (lp == 4'h0) ? 6'h01 : 6'(lp);
		unique case (mux)
			sdft_pkg::MUX_STATIC: pre_len = 6'(p * sdft_pkg::PRE_STATIC);
			sdft_pkg::MUX_HALF: pre_len = 6'(p * sdft_pkg::PRE_HALF);
			default: pre_len = 6'(p * sdft_pkg::PRE_MULTI);
		endcase
	endfunction : pre_len

	// ==========================================================
	// registers and state
	logic [7:0] pixel_data [12];
	logic display_enable, sleep_stop_enable, write_error_flag, wave_b;
	logic [1:0] clk_select, common_count_select;
	logic [3:0] frame_prescale_select;
	logic irq_flag;
	sdft_pkg::sdft_state_t state;
	logic [7:0] sysdiv_cnt;
	logic [5:0] pre_cnt;
	logic [4:0] sub_cnt;
	logic [1:0] slot;
	logic frame_par, wr_window;
	logic [18:0] row_data;
	logic sec_s1, sec_s2, sec_s3, lf_s1, lf_s2, lf_s3;
	logic [7:0] aw_addr, ar_addr;
	logic aw_bad, ar_bad;
	logic [31:0] w_data;
	logic w_lane0;

	// ==========================================================
	// oscillator pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{sec_s1, sec_s2, sec_s3} <= 3'h0;
			{lf_s1, lf_s2, lf_s3} <= 3'h0;
		end else if (clk_en) begin
			{sec_s3, sec_s2, sec_s1} <= {sec_s2, sec_s1, sec_osc_pin};
			{lf_s3, lf_s2, lf_s1} <= {lf_s2, lf_s1, lf_osc_pin};
		end
	end

	// ==========================================================
	// display clock and frame sequencing
	wire sysdiv_tick = (sysdiv_cnt == sdft_pkg::SYSDIV_LAST);
	wire sec_tick = sec_s2 & ~sec_s3;
	wire lf_tick = lf_s2 & ~lf_s3;
	wire disp_tick = (clk_select == sdft_pkg::CS_SYSDIV) ? sysdiv_tick :
		(clk_select == sdft_pkg::CS_SEC) ? sec_tick :
		(clk_select == sdft_pkg::CS_LF) ? lf_tick : 1'b0;
	wire active = (state != sdft_pkg::ST_IDLE);
	wire halt = sleep_cmd & (clk_select == sdft_pkg::CS_SYSDIV);
	wire stop = sleep_cmd & sleep_stop_enable;
	wire is_static = (common_count_select == sdft_pkg::MUX_STATIC);
	wire [5:0] pre_last = 6'(pre_len(common_count_select,
		frame_prescale_select) - 6'h01);
	wire sub_adv = active & ~halt & ~stop & disp_tick &
		(pre_cnt == pre_last);
	wire slot_end = sub_adv & (sub_cnt == sdft_pkg::SLOT_LAST);
	wire last_slot = (slot == common_count_select);
	wire [1:0] next_slot = last_slot ? 2'h0 : 2'(slot + 2'h1);
	wire frame_end = slot_end & last_slot;
	// all rows are read once the last slot is entered
	wire reads_done = slot_end & (next_slot == common_count_select);
	wire frame_evt = reads_done & wave_b & ~is_static &
		frame_par;
	wire shut_evt = frame_end & (state == sdft_pkg::ST_DRAIN);
	wire start_run = (state == sdft_pkg::ST_IDLE) & display_enable;
	wire phase = wave_b ? frame_par : sub_cnt[4];
	wire [18:0] next_row;

	genvar g;
	generate
		for (g = 0; g < sdft_pkg::NUM_SEG; g++) begin : g_row
			assign next_row[g] = pixel_bit(pixel_data,
				start_run ? 2'h0 : next_slot, g);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sysdiv_cnt <= 8'h00;
		end else if (clk_en) begin
			sysdiv_cnt <= 8'(sysdiv_cnt + 8'h01);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt <= 6'h00;
		end else if (clk_en && (start_run || sub_adv)) begin
			pre_cnt <= 6'h00;
		end else if (clk_en && active && !halt && !stop && disp_tick) begin
			pre_cnt <= 6'(pre_cnt + 6'h01);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sub_cnt <= 5'h00;
			slot <= 2'h0;
			frame_par <= 1'b0;
			row_data <= 19'h00000;
		end else if (clk_en && (start_run || slot_end)) begin
			sub_cnt <= 5'h00;
			slot <= start_run ? 2'h0 : next_slot;
			frame_par <= start_run ? 1'b0 : frame_par ^ last_slot;
			row_data <= next_row;
		end else if (clk_en && sub_adv) begin
			sub_cnt <= 5'(sub_cnt + 5'h01);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= sdft_pkg::ST_IDLE;
		end else if (clk_en) begin
			unique case (state)
				sdft_pkg::ST_IDLE: if (display_enable) state <= sdft_pkg::ST_RUN;
				sdft_pkg::ST_RUN: if (!display_enable) begin
					state <= sdft_pkg::ST_DRAIN;
				end
				sdft_pkg::ST_DRAIN: if (frame_end) begin
					state <= sdft_pkg::ST_IDLE;
				end
				default: state <= sdft_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_window <= 1'b0;
		end else if (clk_en) begin
			wr_window <= frame_evt | (wr_window & ~frame_end);
		end
	end

	// ==========================================================
	// waveform levels
	logic [7:0] next_com;
	logic [37:0] next_seg;
	always_comb begin
		next_com = 8'h00;
		next_seg = 38'h0;
		for (int c = 0; c < sdft_pkg::NUM_COM; c++) begin
			if (c[1:0] == slot) begin
				next_com[2*c +: 2] = phase ? sdft_pkg::LVL3 : sdft_pkg::LVL0;
			end else if (c[1:0] <= common_count_select && !is_static) begin
				next_com[2*c +: 2] = phase ? sdft_pkg::LVL1 :
					sdft_pkg::LVL2;
			end
		end
		for (int s = 0; s < sdft_pkg::NUM_SEG; s++) begin
			if (row_data[s]) begin
				next_seg[2*s +: 2] = phase ? sdft_pkg::LVL0 :
					sdft_pkg::LVL3;
			end else if (is_static) begin
				next_seg[2*s +: 2] = phase ? sdft_pkg::LVL3 : sdft_pkg::LVL0;
			end else begin
				next_seg[2*s +: 2] = phase ? sdft_pkg::LVL2 :
					sdft_pkg::LVL1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			backplane_lvl <= 8'h00;
			segment_line_lvl <= 38'h0;
		end else if (clk_en && (stop || !active)) begin
			backplane_lvl <= 8'h00;
			segment_line_lvl <= 38'h0;
		end else if (clk_en && !halt) begin
			backplane_lvl <= next_com;
			segment_line_lvl <= next_seg;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire wr_data_hit = ~aw_bad & (aw_addr < sdft_pkg::CTRL_ADDR) &
		(aw_addr[1:0] == 2'h0);
	wire wr_ctrl = ~aw_bad & (aw_addr == sdft_pkg::CTRL_ADDR);
	wire wr_presc = ~aw_bad & (aw_addr == sdft_pkg::PRESC_ADDR);
	wire wr_stat = ~aw_bad & (aw_addr == sdft_pkg::STAT_ADDR);
	wire wr_hit = wr_data_hit | wr_ctrl | wr_presc | wr_stat;
	wire [3:0] wr_idx = aw_addr[5:2];
	wire px_allowed = ~active | ~wave_b | is_static | wr_window;
	wire px_write = do_write & w_lane0 & wr_data_hit;
	wire px_reject = px_write & ~px_allowed;
	wire ctrl_write = do_write & w_lane0 & wr_ctrl;
	wire rd_data_hit = (ar_addr < sdft_pkg::CTRL_ADDR) &
		(ar_addr[1:0] == 2'h0);
	wire [7:0] ctrl_val = {display_enable, sleep_stop_enable,
		write_error_flag, wave_b, clk_select, common_count_select};
	wire [7:0] rd_val = rd_data_hit ? pixel_data[ar_addr[5:2]] :
		(ar_addr == sdft_pkg::CTRL_ADDR) ? ctrl_val :
		(ar_addr == sdft_pkg::PRESC_ADDR) ? {4'h0, frame_prescale_select} :
		(ar_addr == sdft_pkg::STAT_ADDR) ? {6'h00, irq_flag, active} :
		8'h00;
	wire rd_hit = ~ar_bad & (rd_data_hit |
		(ar_addr == sdft_pkg::CTRL_ADDR) |
		(ar_addr == sdft_pkg::PRESC_ADDR) | (ar_addr == sdft_pkg::STAT_ADDR));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sdft_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			aw_bad <= 1'b0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
		end else if (clk_en) begin
			// low address byte latched, upper bits folded into aw_bad: the master may move the address
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr[7:0];
				aw_bad <= |s_axi_awaddr[31:8];
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ?
					sdft_pkg::RESP_OKAY : sdft_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= sdft_pkg::RESP_OKAY;
			ar_addr <= 8'h00;
			ar_bad <= 1'b0;
		end else if (clk_en) begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				ar_addr <= s_axi_araddr[7:0];
				ar_bad <= |s_axi_araddr[31:8];
			end else if (!s_axi_arready && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h0, rd_val};
				s_axi_rresp <= rd_hit ? sdft_pkg::RESP_OKAY :
					sdft_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// register file
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < sdft_pkg::NUM_DATA; i++) begin
				pixel_data[i] <= sdft_pkg::PIXEL_RESET;
			end
		end else if (clk_en && px_write && px_allowed) begin
			pixel_data[wr_idx] <= w_data[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{display_enable, sleep_stop_enable, wave_b} <= 3'h0;
			clk_select <= sdft_pkg::CTRL_RESET[3:2];
			common_count_select <= sdft_pkg::CTRL_RESET[1:0];
			frame_prescale_select <= sdft_pkg::PRESC_RESET;
		end else if (clk_en && ctrl_write) begin
			display_enable <= w_data[sdft_pkg::CTRL_EN];
			sleep_stop_enable <= w_data[sdft_pkg::CTRL_SLP];
			wave_b <= w_data[sdft_pkg::CTRL_WAVEB];
			clk_select <= w_data[sdft_pkg::CTRL_CS_LO +: 2];
			common_count_select <= w_data[sdft_pkg::CTRL_MUX_LO +: 2];
		end else if (clk_en && do_write && w_lane0 && wr_presc) begin
			frame_prescale_select <= w_data[3:0];
		end
	end

	// set wins over a software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_error_flag <= 1'b0;
			irq_flag <= 1'b0;
			display_irq <= 1'b0;
		end else if (clk_en) begin
			write_error_flag <= px_reject | (write_error_flag &
				~(ctrl_write & ~w_data[sdft_pkg::CTRL_WRITE_ERROR_FLAG]));
			irq_flag <= frame_evt | shut_evt | (irq_flag &
				~(do_write & w_lane0 & wr_stat &
				w_data[sdft_pkg::STAT_IRQ]));
			display_irq <= frame_evt | shut_evt | (irq_flag &
				~(do_write & w_lane0 & wr_stat & w_data[sdft_pkg::STAT_IRQ]));
		end
	end
endmodule : sdft_top

// file: verif/sdft_props.sv
/*
 * Checker for sdft_top: bus answers, sleep levels, irq flag holding.
 * Assumes the master offers write address and data together.
 */
`timescale 1ns/1ps
module sdft_props (
	input wire logic aclk, // clock
	input wire logic aresetn, // synchronous reset
	input wire logic clk_en, // clock enable
	input wire logic sleep_cmd, // processor asleep
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	input wire logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	input wire logic s_axi_wready, // write data ready
	input wire logic s_axi_bvalid, // write response valid
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read data valid
	input wire logic [7:0] backplane_lvl, // common levels
	input wire logic [37:0] segment_line_lvl, // segment levels
	input wire logic display_irq // irq flag
);
	// ==========================================================
	// control shadow
	logic [7:0] ctl;
	wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && clk_en && s_axi_wstrb[0];
	wire ar_hs = s_axi_arvalid && s_axi_arready && clk_en;
	wire ctl_wr = wr_hs && s_axi_awaddr == 32'h00000030;
	wire irq_clr = wr_hs && s_axi_awaddr == 32'h00000038
		&& s_axi_wdata[sdft_pkg::STAT_IRQ];
	wire quiet = ctl[sdft_pkg::CTRL_EN] && (!ctl[sdft_pkg::CTRL_WAVEB]
		|| ctl[1:0] == sdft_pkg::MUX_STATIC);
	wire stop = sleep_cmd && clk_en && ctl[sdft_pkg::CTRL_SLP];
	wire halt = sleep_cmd && clk_en && !ctl[sdft_pkg::CTRL_SLP]
		&& ctl[3:2] == sdft_pkg::CS_SYSDIV;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctl <= sdft_pkg::CTRL_RESET;
		else if (ctl_wr)
			ctl <= s_axi_wdata[7:0];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_SLEEP_MIN: assert property (stop |-> ##[1:2]
		(backplane_lvl == 8'h00 && segment_line_lvl == 38'h0))
		else $error("levels not minimum in sleep");
	AST_SYSDIV_HALT: assert property (halt [*2] |->
		$stable(backplane_lvl) && $stable(segment_line_lvl))
		else $error("levels moved while halted");
	AST_IRQ_HOLD: assert property ($fell(display_irq) && $past(aresetn)
		|-> $past(irq_clr) || $past(irq_clr, 2))
		else $error("irq flag fell without clear");
	AST_NO_FRAME_IRQ: assert property (quiet [*8] |->
		!$rose(display_irq)) else $error("frame irq in quiet mode");
	AST_W_ANSWER: assert property (wr_hs |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	AST_RD_SLVERR: assert property (ar_hs && s_axi_araddr > 32'h3B |->
		##[1:3] (s_axi_rvalid && s_axi_rresp == sdft_pkg::RESP_SLVERR))
		else $error("unmapped read not refused");
	AST_AW_REFUSE: assert property (wr_hs |=> !s_axi_awready)
		else $error("write address ready too early");
	AST_AR_REFUSE: assert property (ar_hs |=> !s_axi_arready)
		else $error("read address ready too early");
endmodule : sdft_props
bind sdft_top sdft_props u_props (.aclk, .aresetn, .clk_en, .sleep_cmd,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
	.s_axi_rvalid, .backplane_lvl, .segment_line_lvl, .display_irq);

// file: verif/sdft_glass_model.sv
/*
 * Passive glass: sums backplane_0 minus seg0/seg1 over each frame.
 * Assumes a frame starts where common 0 rises to the top level.
 */
`timescale 1ns/1ps
module sdft_glass_model (
	input wire logic aclk, // clock
	input wire logic [7:0] backplane_lvl, // common levels
	input wire logic [37:0] segment_line_lvl, // segment levels
	output int frame_len, // cycles of last frame
	output int frames, // frame starts seen
	output int dc0, // net sum, pixel backplane_0 seg0
	output int dc1, // net sum, pixel backplane_0 seg1
	output int sq0, // square sum, backplane_0 seg0
	output int sq1 // square sum, backplane_0 seg1
);
	int cnt = 0, a0 = 0, a1 = 0, s0 = 0, s1 = 0, d0, d1;
	logic [1:0] prev = 2'h0;
	initial frames = 0;
	always @(posedge aclk) begin
		d0 = int'(backplane_lvl[1:0]) - int'(segment_line_lvl[1:0]);
		d1 = int'(backplane_lvl[1:0]) - int'(segment_line_lvl[3:2]);
		if (backplane_lvl[1:0] == sdft_pkg::LVL3 && prev != sdft_pkg::LVL3) begin
			frame_len <= cnt;
			frames <= frames + 1;
			dc0 <= a0;
			dc1 <= a1;
			sq0 <= s0;
			sq1 <= s1;
			cnt = 0;
			a0 = 0;
			a1 = 0;
			s0 = 0;
			s1 = 0;
		end
		cnt++;
		a0 += d0;
		a1 += d1;
		s0 += d0 * d0;
		s1 += d1 * d1;
		prev = backplane_lvl[1:0];
	end
endmodule : sdft_glass_model

// file: verif/segment_display_frame_timing_tb.sv
/*
 * Bench for sdft_top: register bus tasks, frame rates, write window,
 * shutdown and sleep. Assumes the glass model on the level outputs.
 */
`timescale 1ns/1ps
module segment_display_frame_timing_tb;
	logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, sleep_cmd = 1'b0;
	logic sec_osc = 1'b0, lf_osc = 1'b0, bready = 1'b0, rready = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rv;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] resp;
	logic [45:0] hold;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] bp;
	wire [37:0] sg;
	int frame_len, frames, dc0, dc1, sq0, sq1, t0, i;
	int err_total = 0, tests_run = 0, cyc = 0;
	always #2.5 aclk = ~aclk;
	always #10 sec_osc = ~sec_osc;
	always #15 lf_osc = ~lf_osc;
	always @(posedge aclk) cyc <= cyc + 1;
	sdft_top u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.sleep_cmd(sleep_cmd), .sec_osc_pin(sec_osc), .lf_osc_pin(lf_osc),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .backplane_lvl(bp), .segment_line_lvl(sg),
		.display_irq(irq));
	sdft_glass_model u_glass (.aclk(aclk), .backplane_lvl(bp),
		.segment_line_lvl(sg), .frame_len(frame_len), .frames(frames),
		.dc0(dc0), .dc1(dc1), .sq0(sq0), .sq1(sq1));
	// ==========================================================
	// tasks
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task fail_to;
		err_total++;
		$display("BAD %0t: wait ran out", $time);
		summarize();
	endtask : fail_to
	task chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			fail_to();
	endtask : wr
	task rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rv = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			fail_to();
	endtask : rd
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rchk
	task wait_irq;
		int n;
		for (n = 0; n < 5000; n++) begin
			@(posedge aclk);
			if (irq === 1'b1)
				break;
		end
		if (n == 5000)
			fail_to();
	endtask : wait_irq
	task wait_frames;
		int n, f;
		f = frames;
		for (n = 0; n < 20000; n++) begin
			@(posedge aclk);
			if (frames >= f + 3)
				break;
		end
		if (n == 20000)
			fail_to();
	endtask : wait_frames
	// ==========================================================
	// sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 12; i++)
			rchk(8'(4 * i), {24'h0, sdft_pkg::PIXEL_RESET});
		rchk(sdft_pkg::CTRL_ADDR, {24'h0, sdft_pkg::CTRL_RESET});
		rchk(sdft_pkg::PRESC_ADDR, {28'h0, sdft_pkg::PRESC_RESET});
		rchk(sdft_pkg::STAT_ADDR, 32'h0);
		rd(8'h3C);
		chk(resp, sdft_pkg::RESP_SLVERR);
		wr(8'h3C, 32'h1);
		chk(resp, sdft_pkg::RESP_SLVERR);
		$display("test reset done");
		wr(sdft_pkg::PRESC_ADDR, 32'h2);
		chk(resp, sdft_pkg::RESP_OKAY);
		wr(8'h00, 32'h01);
		rchk(8'h00, 32'h01);
		wstrb <= 4'h0;
		wr(8'h00, 32'hFF);
		chk(resp, sdft_pkg::RESP_OKAY);
		wstrb <= 4'hF;
		rchk(8'h00, 32'h01);
		for (i = 0; i < 4; i++) begin
			wr(sdft_pkg::CTRL_ADDR, 32'h84 + i);
			wait_frames();
			chk(frame_len, (i == 0 ? 4 : i == 1 ? 2 : 1) * 256 * (i + 1));
		end
		chk(dc0, 0);
		chk(dc1, 0);
		chk(sq0 > sq1, 1);
		wr(sdft_pkg::CTRL_ADDR, 32'h8B);
		wait_frames();
		chk(frame_len, 2 * 32 * 4 * 6);
		// clock enable low must freeze the running waveform
		clk_en <= 1'b0;
		@(posedge aclk);
		hold = {bp, sg};
		repeat (3000) @(posedge aclk);
		chk({bp, sg}, hold);
		clk_en <= 1'b1;
		$display("test rate done");
		wr(sdft_pkg::CTRL_ADDR, 32'h97);
		wr(sdft_pkg::STAT_ADDR, 32'h2);
		wr(8'h0C, 32'h5A);
		rchk(8'h0C, 32'h0);
		rchk(sdft_pkg::CTRL_ADDR, 32'hB7);
		wait_irq();
		t0 = cyc;
		wr(8'h0C, 32'h5A);
		rchk(8'h0C, 32'h5A);
		rchk(sdft_pkg::STAT_ADDR, 32'h3);
		wr(sdft_pkg::STAT_ADDR, 32'h2);
		rchk(sdft_pkg::STAT_ADDR, 32'h1);
		wr(sdft_pkg::CTRL_ADDR, 32'h97);
		rchk(sdft_pkg::CTRL_ADDR, 32'h97);
		wait_irq();
		chk(cyc - t0, 2 * 2 * 32 * 4 * 4);
		$display("test window done");
		wr(sdft_pkg::CTRL_ADDR, 32'h87);
		wr(sdft_pkg::STAT_ADDR, 32'h2);
		repeat (3000) @(posedge aclk);
		chk(irq, 1'b0);
		wr(sdft_pkg::CTRL_ADDR, 32'h94);
		repeat (2500) @(posedge aclk);
		chk(irq, 1'b0);
		wr(sdft_pkg::CTRL_ADDR, 32'h14);
		rchk(sdft_pkg::STAT_ADDR, 32'h1);
		wait_irq();
		rchk(sdft_pkg::STAT_ADDR, 32'h2);
		wr(sdft_pkg::STAT_ADDR, 32'h2);
		$display("test shutdown done");
		wr(sdft_pkg::CTRL_ADDR, 32'hC7);
		repeat (200) @(posedge aclk);
		sleep_cmd <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({bp, sg}, 46'h0);
		sleep_cmd <= 1'b0;
		wr(sdft_pkg::CTRL_ADDR, 32'h83);
		repeat (1000) @(posedge aclk);
		sleep_cmd <= 1'b1;
		repeat (2) @(posedge aclk);
		hold = {bp, sg};
		repeat (9000) @(posedge aclk);
		chk({bp, sg}, hold);
		sleep_cmd <= 1'b0;
		wr(sdft_pkg::CTRL_ADDR, 32'h0);
		$display("test sleep done");
		summarize();
	end
endmodule : segment_display_frame_timing_tb
